// *** hdl/rxpc_consts.vh ***
// Constants for the receive path control register group.
// Assumes word-addressed CSR port with 32-bit data.
`ifndef RXPC_CONSTS_VH
`define RXPC_CONSTS_VH

// Word offsets
`define RXPC_OFF_PATH_DISABLE 8'h00
`define RXPC_OFF_PATH_STATE 8'h01
`define RXPC_OFF_STRIP_CTRL 8'h40
`define RXPC_OFF_FCS_CHECK 8'h80
`define RXPC_OFF_TRUNC_LO 8'hC0
`define RXPC_OFF_TRUNC_HI 8'hC1

// Field positions
`define RXPC_BIT_DISABLE 0
`define RXPC_BIT_STRIP_FCS 0
`define RXPC_BIT_STRIP_PAD 1
`define RXPC_BIT_CHECK_FCS 1

// Reset values
`define RXPC_RST_DISABLE 1'h0
`define RXPC_RST_STRIP 2'h1
`define RXPC_RST_CHECK 2'h2

// Widths and sizes
`define RXPC_CNT_W 36
`define RXPC_ADDR_W 8
`define RXPC_FCS_BYTES 3'h4
`define RXPC_MIN_PAYLOAD 16'h002E

`endif

// *** hdl/rxpc_skid_buf.v ***
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rxpc_skid_buf #(
    parameter W = 72
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_ff [0:1];
    reg wr_ptr_ff;
    reg rd_ptr_ff;
    reg [1:0] cnt_ff;
    wire push;
    wire pop;

    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // rxpc_skid_buf
`default_nettype wire

// *** hdl/rxpc_regs.v ***
// Receive path control and status registers with frame stream filter.
// Assumes a word-addressed CSR port and a 64-bit receive stream whose
// upstream marks FCS bytes, pad bytes and CRC result per beat.
`timescale 1ns/1ps
`default_nettype none
`include "rxpc_consts.vh"
module rxpc_regs (
    // Clock and reset
    input wire clk,
    input wire rst,
    // CSR port
    input wire [7:0] csr_address,
    input wire csr_read,
    input wire csr_write,
    input wire [31:0] csr_writedata,
    output reg [31:0] csr_readdata,
    // Receive stream from the MAC core
    input wire in_valid,
    output wire in_ready,
    input wire [63:0] in_data,
    input wire in_sop,
    input wire in_eop,
    input wire [7:0] in_byte_en,
    input wire [7:0] in_fcs_bytes,
    input wire [7:0] in_pad_bytes,
    input wire in_crc_bad,
    input wire in_overflow_trunc,
    // Receive stream to the client
    output wire rx_stream_valid,
    input wire rx_stream_ready,
    output wire [63:0] rx_stream_data_out,
    output wire rx_stream_sop,
    output wire rx_stream_eop,
    output wire [7:0] rx_stream_byte_en,
    output wire rx_stream_crc_err
);
    // Packing of one buffered beat, high to low
    localparam BUF_W = 75;
    localparam BP_SOP = 74;
    localparam BP_EOP = 73;
    localparam BP_BE_HI = 72;
    localparam BP_BE_LO = 65;
    localparam BP_D_HI = 64;
    localparam BP_D_LO = 1;
    localparam BP_ERR = 0;
    localparam [`RXPC_CNT_W-1:0] CNT_ONE = {{(`RXPC_CNT_W-1){1'b0}}, 1'b1};

    reg disable_ff;
    reg [1:0] strip_ff;
    reg [1:0] check_ff;
    reg [`RXPC_CNT_W-1:0] trunc_cnt_ff;
    reg drop_frame_ff;
    reg [31:0] nxt_readdata;
    reg [7:0] keep_en;
    reg [`RXPC_CNT_W-1:0] nxt_cnt;
    wire drop_now;
    wire beat_take;
    wire fwd_valid;
    wire [BUF_W-1:0] buf_in;
    wire [BUF_W-1:0] buf_out;
    wire buf_in_ready;
    wire hi_read;
    wire trunc_event;
    wire crc_flag;
    reg in_frame_ff;

    // Offset match shared by write strobes and the clearing read
    function addr_is;
        input [7:0] addr;
        input [7:0] off;
        begin
            addr_is = (addr == off);
        end
    endfunction

    // CSR write strobe for one word offset
    function wr_hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            wr_hit = csr_write && addr_is(addr, off);
        end
    endfunction

    // Register writes; reserved bits dropped
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            disable_ff <= `RXPC_RST_DISABLE;
            strip_ff <= `RXPC_RST_STRIP;
            check_ff <= `RXPC_RST_CHECK;
        end else begin
            if (wr_hit(csr_address, `RXPC_OFF_PATH_DISABLE)) begin
                disable_ff <= csr_writedata[`RXPC_BIT_DISABLE];
            end
            if (wr_hit(csr_address, `RXPC_OFF_STRIP_CTRL)) begin
                strip_ff <= csr_writedata[1:0];
            end
            if (wr_hit(csr_address, `RXPC_OFF_FCS_CHECK)) begin
                check_ff <= csr_writedata[1:0];
            end
        end
    end

    // Read mux
    always @* begin
        nxt_readdata = 32'h00000000;
        case (csr_address)
            `RXPC_OFF_PATH_DISABLE: nxt_readdata[0] = disable_ff;
            `RXPC_OFF_PATH_STATE: nxt_readdata[0] = disable_ff;
            `RXPC_OFF_STRIP_CTRL: nxt_readdata[1:0] = strip_ff;
            `RXPC_OFF_FCS_CHECK: nxt_readdata[1:0] = check_ff;
            `RXPC_OFF_TRUNC_LO: nxt_readdata = trunc_cnt_ff[31:0];
            `RXPC_OFF_TRUNC_HI: nxt_readdata[3:0] = trunc_cnt_ff[35:32];
            default: nxt_readdata = 32'h00000000;
        endcase
    end

    // Read data is captured only on a read strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            csr_readdata <= 32'h00000000;
        end else if (csr_read) begin
            csr_readdata <= nxt_readdata;
        end
    end

    // Truncation counter; a count in the clearing cycle survives
    assign hi_read = csr_read && addr_is(csr_address, `RXPC_OFF_TRUNC_HI);
    assign beat_take = in_valid && in_ready;
    assign trunc_event = beat_take && in_eop && in_overflow_trunc;

    always @* begin
        nxt_cnt = trunc_cnt_ff;
        if (hi_read) begin
            nxt_cnt = {`RXPC_CNT_W{1'b0}};
        end
        if (trunc_event) begin
            nxt_cnt = nxt_cnt + CNT_ONE;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            trunc_cnt_ff <= {`RXPC_CNT_W{1'b0}};
        end else begin
            trunc_cnt_ff <= nxt_cnt;
        end
    end

    // Drop decision latched at start of frame so frames stay whole
    assign drop_now = in_sop ? disable_ff :
                      (in_frame_ff ? drop_frame_ff : disable_ff);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            drop_frame_ff <= 1'b0;
        end else if (beat_take && in_sop) begin
            drop_frame_ff <= disable_ff;
        end
    end

    // Open-frame flag; beats outside a frame follow the live disable bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            in_frame_ff <= 1'b0;
        end else if (beat_take) begin
            in_frame_ff <= !in_eop && (in_sop || in_frame_ff);
        end
    end

    // Byte stripping
    always @* begin
        keep_en = in_byte_en;
        if (strip_ff[`RXPC_BIT_STRIP_PAD]) begin
            keep_en = in_byte_en & ~in_fcs_bytes & ~in_pad_bytes;
        end else if (strip_ff[`RXPC_BIT_STRIP_FCS]) begin
            keep_en = in_byte_en & ~in_fcs_bytes;
        end
    end

    // Beats left empty by stripping are dropped unless they close the frame
    assign fwd_valid = in_valid && !drop_now && ((keep_en != 8'h00) || in_eop);
    assign in_ready = buf_in_ready || drop_now;
    assign crc_flag = check_ff[`RXPC_BIT_CHECK_FCS] && in_crc_bad;
    assign buf_in = {in_sop, in_eop, keep_en, in_data,
                     crc_flag};

    // Stall buffer toward the client
    rxpc_skid_buf #(
        .W(BUF_W)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(fwd_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(rx_stream_valid),
        .out_ready(rx_stream_ready),
        .out_data(buf_out)
    );

    // Unpack the buffered beat
    assign rx_stream_sop = buf_out[BP_SOP];
    assign rx_stream_eop = buf_out[BP_EOP];
    assign rx_stream_byte_en = buf_out[BP_BE_HI:BP_BE_LO];
    assign rx_stream_data_out = buf_out[BP_D_HI:BP_D_LO];
    assign rx_stream_crc_err = buf_out[BP_ERR];
endmodule // rxpc_regs
`default_nettype wire

// *** verif/rxpc_regs_properties.sv ***
// Checker for the rxpc_regs CSR port and output stream.
// Bound to rxpc_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rxpc_regs_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // CSR port
    input wire logic [7:0] csr_address,
    input wire logic csr_read,
    input wire logic csr_write,
    input wire logic [31:0] csr_writedata,
    input wire logic [31:0] csr_readdata,
    // Streams
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic in_eop,
    input wire logic in_overflow_trunc,
    input wire logic rx_stream_valid,
    input wire logic rx_stream_ready,
    input wire logic [63:0] rx_stream_data_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire cnt_inc = in_valid && in_ready && in_eop && in_overflow_trunc;
    sequence s_hi_rd;
        csr_read && csr_address == 8'hC1 && !cnt_inc ##1 !cnt_inc && !csr_read;
    endsequence
    sequence s_lo_rd;
        csr_read && csr_address == 8'hC0 && !cnt_inc ##1 !cnt_inc && !csr_read;
    endsequence
    sequence s_dis_wr;
        csr_write && csr_address == 8'h00 ##1 !csr_write;
    endsequence
    a_rsvd_read_zero:
        assert property (csr_read && !(csr_address inside {8'h00, 8'h01, 8'h40, 8'h80,
            8'hC0, 8'hC1}) |=> csr_readdata == 32'h0) else $error("reserved read");
    a_dis_bits_zero:
        assert property (csr_read && csr_address inside {8'h00, 8'h01}
            |=> csr_readdata[31:1] == 31'h0) else $error("upper bits set");
    a_hi_upper_zero:
        assert property (csr_read && csr_address == 8'hC1
            |=> csr_readdata[31:4] == 28'h0) else $error("high word bits");
    a_state_mirror:
        assert property (s_dis_wr ##1 csr_read && csr_address == 8'h01 && !csr_write
            |=> csr_readdata[0] == $past(csr_writedata[0], 3)) else $error("state bit");
    a_hi_read_clears:
        assert property (s_hi_rd ##1 csr_read && csr_address == 8'hC0
            |=> csr_readdata == 32'h0) else $error("count not cleared");
    a_lo_read_keeps:
        assert property (s_lo_rd ##1 csr_read && csr_address == 8'hC0
            |=> csr_readdata == $past(csr_readdata, 2)) else $error("count changed");
    a_out_stall_hold:
        assert property (rx_stream_valid && !rx_stream_ready
            |=> rx_stream_valid && $stable(rx_stream_data_out)) else $error("beat lost");
    a_rdata_hold:
        assert property (!csr_read |=> $stable(csr_readdata)) else $error("rdata moved");
endmodule // rxpc_regs_properties
bind rxpc_regs rxpc_regs_properties chk (.clk, .rst, .csr_address, .csr_read, .csr_write,
    .csr_writedata, .csr_readdata, .in_valid, .in_ready, .in_eop, .in_overflow_trunc,
    .rx_stream_valid, .rx_stream_ready, .rx_stream_data_out);
`default_nettype wire

// *** verif/test_rxpc_regs.sv ***
// Bench for rxpc_regs: CSR accesses and receive stream beats.
// Assumes the design and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_rxpc_regs;
    logic clk = 0, rst = 1, rd = 0, wr = 0, iv = 0, sop = 0, eop = 0, bad = 0, tr = 0;
    logic ordy = 1;
    logic [7:0] a = 8'h00, fcs = 8'h00, pad = 8'h00;
    logic [7:0] ben = 8'hFF;
    logic [31:0] wd = 32'h0;
    logic [63:0] d = 64'h0;
    wire [31:0] rdat;
    wire [63:0] od;
    wire [7:0] obe;
    wire irdy, ov, osop, oeop, cerr;
    int err_total = 0, n_compared = 0;
    always #5 clk = ~clk;
    rxpc_regs uut (.clk(clk), .rst(rst), .csr_address(a), .csr_read(rd), .csr_write(wr),
        .csr_writedata(wd), .csr_readdata(rdat), .in_valid(iv), .in_ready(irdy),
        .in_data(d), .in_sop(sop), .in_eop(eop), .in_byte_en(ben), .in_fcs_bytes(fcs),
        .in_pad_bytes(pad), .in_crc_bad(bad), .in_overflow_trunc(tr),
        .rx_stream_valid(ov), .rx_stream_ready(ordy), .rx_stream_data_out(od),
        .rx_stream_sop(osop), .rx_stream_eop(oeop), .rx_stream_byte_en(obe),
        .rx_stream_crc_err(cerr));
    task chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wreg(input logic [7:0] ad, input logic [31:0] v);
        @(negedge clk);
        a = ad;
        wd = v;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task rreg(input logic [7:0] ad, input logic [31:0] e);
        @(negedge clk);
        a = ad;
        rd = 1;
        @(negedge clk);
        rd = 0;
        chk(rdat, e);
    endtask
    task beat(input logic s, e, t, b, input logic [7:0] f, p, input logic [63:0] dv);
        int n;
        @(negedge clk);
        sop = s;
        eop = e;
        tr = t;
        bad = b;
        fcs = f;
        pad = p;
        d = dv;
        iv = 1;
        n = 0;
        while (!irdy && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (!irdy) begin
            err_total++;
            $display("[ERR] %0t beat not accepted", $time);
        end
        @(negedge clk);
        iv = 0;
    endtask
    task close_out;
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        rreg(8'h00, 0);
        rreg(8'h01, 0);
        rreg(8'h40, 1);
        rreg(8'h80, 2);
        rreg(8'hC1, 0);
        wreg(8'h02, 32'hFFFFFFFF);
        rreg(8'h02, 0);
        wreg(8'h00, 32'hFFFFFFFF);
        rreg(8'h01, 1);
        rreg(8'h00, 1);
        beat(1, 1, 1, 0, 8'h00, 8'h00, 64'h0);
        chk(ov, 0);
        wreg(8'h00, 0);
        rreg(8'h01, 0);
        for (int i = 0; i < 4; i++) begin
            wreg(8'h40, i);
            beat(1, 1, 1, 0, 8'hF0, 8'h0C, 64'h0);
            chk(ov, 1);
            chk(osop, 1);
            chk(oeop, 1);
            chk(obe, i[1] ? 8'h03 : i[0] ? 8'h0F : 8'hFF);
        end
        ben = 8'h3F;
        beat(1, 1, 0, 0, 8'h3C, 8'h00, 64'h0);
        chk(obe, 8'h03);
        ben = 8'hFF;
        for (int i = 0; i < 2; i++) begin
            wreg(8'h80, 2 * i);
            beat(1, 1, 0, 1, 8'h00, 8'h00, 64'h0);
            chk(cerr, i);
        end
        rreg(8'hC0, 5);
        rreg(8'hC0, 5);
        rreg(8'hC1, 0);
        rreg(8'hC0, 0);
        ordy = 0;
        beat(1, 0, 0, 0, 8'h00, 8'h00, 64'hA5);
        beat(0, 1, 0, 0, 8'h00, 8'h00, 64'h5A);
        chk(irdy, 0);
        chk(od, 64'hA5);
        chk(osop, 1);
        chk(oeop, 0);
        ordy = 1;
        @(negedge clk);
        chk(od, 64'h5A);
        chk(osop, 0);
        chk(oeop, 1);
        @(negedge clk);
        chk(ov, 0);
        close_out;
    end
    initial begin
        #100000;
        err_total++;
        close_out;
    end
endmodule // test_rxpc_regs
`default_nettype wire
